//--- rtl/trig_pkg.sv
package trig_pkg;
    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TIMEBASE = 8'h04;
    localparam logic [7:0] ADDR_DELAY = 8'h08;
    localparam logic [7:0] ADDR_POSITION = 8'h0C;
    localparam logic [7:0] ADDR_LEVEL = 8'h10;
    localparam logic [7:0] ADDR_OFFSET = 8'h14;
    localparam logic [7:0] ADDR_HOLDOFF = 8'h18;
    localparam logic [7:0] ADDR_COMMAND = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_TRIG_COUNT = 8'h24;
    localparam logic [7:0] ADDR_PRETRIG = 8'h28;
    // Command bits.
    localparam int CMD_ZERO_DELAY = 0;
    localparam int CMD_POS_LEFT = 1;
    localparam int CMD_POS_MIDDLE = 2;
    localparam int CMD_POS_RIGHT = 3;
    localparam int CMD_HOLDOFF_UP = 4;
    localparam int CMD_HOLDOFF_DOWN = 5;
    // Source codes; SRC_CHANNEL0 up picks a channel.
    localparam logic [3:0] SRC_INDEPENDENT = 4'h0;
    localparam logic [3:0] SRC_EXTERNAL = 4'h1;
    localparam logic [3:0] SRC_CHANNEL0 = 4'h2;
    // Timebase indices.
    localparam logic [4:0] TB_FASTEST = 5'h00;
    localparam logic [4:0] TB_SLOWEST = 5'h15;
    localparam logic [4:0] TB_RESET = 5'h0D;
    // Position limits and presets.
    localparam logic signed [7:0] POS_MIN = -8'sd30;
    localparam logic signed [7:0] POS_MAX = 8'sd30;
    localparam logic signed [7:0] POS_LEFT = 8'sd0;
    localparam logic signed [7:0] POS_MIDDLE = 8'sd5;
    localparam logic signed [7:0] POS_RIGHT = 8'sd10;
    // Level in 0.1 dBm, holdoff in 0.01 us.
    localparam logic signed [15:0] LEVEL_MAX = 16'sd200;
    localparam logic [23:0] HOLDOFF_STEP = 24'd100;
    localparam int HOLDOFF_UNIT_NS = 10;
    // Timing.
    localparam int CLK_PERIOD_NS = 100;
    localparam int PRETRIG_MAX_NS = 1260000;
    localparam int AUTO_TIMEOUT_MS = 100;
    localparam int FREERUN_PERIOD_US = 1000;
    localparam int AUTOLEVEL_WINDOW_US = 10000;
    localparam int AUTO_TIMEOUT_CYCLES = AUTO_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int FREERUN_CYCLES = FREERUN_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int AUTOLEVEL_CYCLES = AUTOLEVEL_WINDOW_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {MODE_NORMAL, MODE_AUTO, MODE_AUTOLEVEL, MODE_FREERUN} mode_t;
    typedef enum logic [1:0] {ST_ARM, ST_HOLD, ST_GAP} fsm_t;

    // Trigger settings.
    typedef struct packed {
        mode_t mode;
        logic slope_neg;
        logic gap_mode;
        logic [3:0] source;
        logic [4:0] tb;
        logic signed [31:0] delay;
        logic signed [7:0] pos;
        logic signed [15:0] level;
        logic signed [15:0] offset;
        logic [23:0] holdoff;
    } cfg_t;

    // Unit state.
    typedef struct packed {
        cfg_t cfg;
        fsm_t fsm;
        logic a_valid;
        logic a_wr;
        logic [7:0] a_addr;
        logic ready;
        logic [31:0] rdata;
        logic active_prev;
        logic [23:0] hold_cnt;
        logic [31:0] auto_cnt;
        logic [31:0] win_cnt;
        logic signed [15:0] pk_max;
        logic signed [15:0] pk_min;
        logic dly_run;
        logic [31:0] dly_cnt;
        logic [31:0] trig_count;
        logic trig_out;
        logic sweep_start;
        logic slave_mode;
        logic [15:0] pretrig;
        logic [3:0] decim;
    } state_t;

    localparam state_t STATE_RESET = '{cfg: '{mode: MODE_NORMAL, tb: TB_RESET, default: '0},
                                       fsm: ST_ARM, default: '0};

    // Nanoseconds per division.
    function automatic logic [31:0] tb_ns(input logic [4:0] idx);
        logic [31:0] mant;
        logic [31:0] dec;
        mant = (idx % 5'd3 == 5'd0) ? 32'd5 : (idx % 5'd3 == 5'd1) ? 32'd10 : 32'd20;
        dec = 32'd1;
        for (int i = 0; i < 7; i++)
        begin
            if (i < int'(idx / 5'd3))
            begin
                dec = dec * 32'd10;
            end
        end
        return mant * dec;
    endfunction

    // Most negative delay in ns.
    function automatic logic signed [31:0] delay_min(input logic [4:0] idx);
        case (idx)
            5'h0B: return -32'sd1260000;
            5'h0C: return -32'sd5040000;
            5'h0D: return -32'sd6300000;
            5'h0E: return -32'sd12600000;
            5'h0F: return -32'sd31500000;
            5'h10: return -32'sd63000000;
            5'h11, 5'h12, 5'h13: return -32'sd126000000;
            5'h14: return -32'sd252000000;
            5'h15: return -32'sd628000000;
            default: return -32'sd1260000;
        endcase
    endfunction

    // Longest positive delay in ns.
    function automatic logic signed [31:0] delay_max(input logic [4:0] idx);
        case (idx)
            5'h0B, 5'h0C: return 32'sd200000000;
            5'h0D: return 32'sd500000000;
            default: return (idx < 5'h0B) ? 32'sd100000000 : 32'sd1000000000;
        endcase
    endfunction
endpackage

//--- rtl/acquisition_trigger_unit.sv
`timescale 1ns/100ps
// Summary of operation
// - Timebase runs 1-2-5 from 5 ns to 50 ms/div.
// - Delay shifts the capture after or before the trigger.
// - Zero command clears the delay.
// - Delay is clamped per timebase.
// - Long pre-trigger lowers the sample rate.
// - Position spans -30 to +30 divisions.
// - Presets set position 0, 5 or 10.
// - Source: sensor channel, external or independent.
// - A channel source makes its sensor master, others slave.
// - Normal mode fires only on crossings.
// - Auto mode self-sweeps on timeout, resyncs on edges.
// - Auto-level derives the level from peak-to-peak.
// - Free-run sweeps and ignores triggers.
// - Level is capped at 20 dBm.
// - Offset shifts level and range by its signed value.
// - Slope picks rising or falling crossings.
// - Holdoff in 0.01 us units, 1 us steps.
// - Normal holdoff blocks triggers after each one.
// - Gap holdoff arms after a long enough inactive spell.
module acquisition_trigger_unit #(
    parameter logic [4:0] TB_MIN_IDX = trig_pkg::TB_FASTEST,
    parameter logic [4:0] TB_MAX_IDX = trig_pkg::TB_SLOWEST,
    parameter logic signed [15:0] LEVEL_MIN = -16'sd400,
    parameter int AUTO_TIMEOUT = trig_pkg::AUTO_TIMEOUT_CYCLES,
    parameter int FREERUN_PERIOD = trig_pkg::FREERUN_CYCLES,
    parameter int AUTOLEVEL_WINDOW = trig_pkg::AUTOLEVEL_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic signed [15:0] rf_sample,
    input wire logic ext_trig_in,
    input wire logic slave_trig_in,
    input wire logic [3:0] own_channel,
    output logic trig_out,
    output logic sweep_start,
    output logic slave_mode,
    output logic [15:0] pretrig_samples,
    output logic [3:0] decim_shift
);
    trig_pkg::state_t st_reg;
    trig_pkg::state_t st_next;
    logic signed [15:0] thr;
    logic signed [16:0] lvl_wide;
    logic signed [16:0] pk_sum;
    logic signed [31:0] lim_lo;
    logic signed [31:0] lim_hi;
    logic signed [15:0] lvl_lo;
    logic signed [15:0] lvl_hi;
    logic src_level;
    logic is_master;
    logic is_slave;
    logic active;
    logic edge_hit;
    logic accept;
    logic forced;
    logic [23:0] hold_cycles;
    logic [31:0] dly_cycles;
    logic signed [47:0] pre_ns;
    logic [47:0] pre_pos;
    int dec;

    // Whole next-state logic.
    always_comb
    begin
        st_next = st_reg;
        st_next.ready = 1'b1;
        st_next.trig_out = 1'b0;
        st_next.sweep_start = 1'b0;
        accept = 1'b0;
        forced = 1'b0;

        // Data phase write to the latched address.
        if (st_reg.a_valid && st_reg.a_wr)
        begin
            case (st_reg.a_addr)
                trig_pkg::ADDR_CTRL:
                begin
                    st_next.cfg.mode = trig_pkg::mode_t'(hwdata[1:0]);
                    st_next.cfg.slope_neg = hwdata[2];
                    st_next.cfg.gap_mode = hwdata[3];
                    st_next.cfg.source = hwdata[7:4];
                end
                trig_pkg::ADDR_TIMEBASE: st_next.cfg.tb = hwdata[4:0];
                trig_pkg::ADDR_DELAY: st_next.cfg.delay = $signed(hwdata);
                trig_pkg::ADDR_POSITION: st_next.cfg.pos = $signed(hwdata[7:0]);
                trig_pkg::ADDR_LEVEL: st_next.cfg.level = $signed(hwdata[15:0]);
                trig_pkg::ADDR_OFFSET:
                begin
                    st_next.cfg.level = st_reg.cfg.level + $signed(hwdata[15:0])
                        - st_reg.cfg.offset;
                    st_next.cfg.offset = $signed(hwdata[15:0]);
                end
                trig_pkg::ADDR_HOLDOFF: st_next.cfg.holdoff = hwdata[23:0];
                trig_pkg::ADDR_COMMAND:
                begin
                    if (hwdata[trig_pkg::CMD_ZERO_DELAY])
                    begin
                        st_next.cfg.delay = 32'sd0;
                    end
                    if (hwdata[trig_pkg::CMD_POS_LEFT])
                    begin
                        st_next.cfg.pos = trig_pkg::POS_LEFT;
                    end
                    if (hwdata[trig_pkg::CMD_POS_MIDDLE])
                    begin
                        st_next.cfg.pos = trig_pkg::POS_MIDDLE;
                    end
                    if (hwdata[trig_pkg::CMD_POS_RIGHT])
                    begin
                        st_next.cfg.pos = trig_pkg::POS_RIGHT;
                    end
                    if (hwdata[trig_pkg::CMD_HOLDOFF_UP])
                    begin
                        st_next.cfg.holdoff = st_reg.cfg.holdoff + trig_pkg::HOLDOFF_STEP;
                    end
                    if (hwdata[trig_pkg::CMD_HOLDOFF_DOWN])
                    begin
                        st_next.cfg.holdoff = (st_reg.cfg.holdoff > trig_pkg::HOLDOFF_STEP) ?
                            st_reg.cfg.holdoff - trig_pkg::HOLDOFF_STEP : 24'h000000;
                    end
                end
                default: ;
            endcase
        end

        // Auto-level tracks the peak-to-peak midpoint.
        st_next.win_cnt = st_reg.win_cnt + 32'd1;
        st_next.pk_max = (rf_sample > st_reg.pk_max) ? rf_sample : st_reg.pk_max;
        st_next.pk_min = (rf_sample < st_reg.pk_min) ? rf_sample : st_reg.pk_min;
        pk_sum = 17'(st_reg.pk_max) + 17'(st_reg.pk_min);
        if (st_reg.win_cnt >= 32'(AUTOLEVEL_WINDOW - 1))
        begin
            st_next.win_cnt = 32'd0;
            st_next.pk_max = rf_sample;
            st_next.pk_min = rf_sample;
            if (st_reg.cfg.mode == trig_pkg::MODE_AUTOLEVEL)
            begin
                st_next.cfg.level = 16'(pk_sum >>> 1) + st_reg.cfg.offset;
            end
        end

        // Clamp settings.
        if (st_next.cfg.tb < TB_MIN_IDX)
        begin
            st_next.cfg.tb = TB_MIN_IDX;
        end
        if (st_next.cfg.tb > TB_MAX_IDX)
        begin
            st_next.cfg.tb = TB_MAX_IDX;
        end
        if (st_next.cfg.pos < trig_pkg::POS_MIN)
        begin
            st_next.cfg.pos = trig_pkg::POS_MIN;
        end
        if (st_next.cfg.pos > trig_pkg::POS_MAX)
        begin
            st_next.cfg.pos = trig_pkg::POS_MAX;
        end
        lim_lo = trig_pkg::delay_min(st_next.cfg.tb);
        lim_hi = trig_pkg::delay_max(st_next.cfg.tb);
        if (st_next.cfg.delay < lim_lo)
        begin
            st_next.cfg.delay = lim_lo;
        end
        if (st_next.cfg.delay > lim_hi)
        begin
            st_next.cfg.delay = lim_hi;
        end
        lvl_lo = LEVEL_MIN + st_next.cfg.offset;
        lvl_hi = trig_pkg::LEVEL_MAX + st_next.cfg.offset;
        if (st_next.cfg.level < lvl_lo)
        begin
            st_next.cfg.level = lvl_lo;
        end
        if (st_next.cfg.level > lvl_hi)
        begin
            st_next.cfg.level = lvl_hi;
        end

        // Source and role.
        lvl_wide = 17'(st_reg.cfg.level) - 17'(st_reg.cfg.offset);
        thr = 16'(lvl_wide);
        is_master = 1'b0;
        is_slave = 1'b0;
        if (st_reg.cfg.source == trig_pkg::SRC_EXTERNAL)
        begin
            src_level = ext_trig_in;
        end
        else if (st_reg.cfg.source >= trig_pkg::SRC_CHANNEL0 &&
                 st_reg.cfg.source - trig_pkg::SRC_CHANNEL0 != own_channel)
        begin
            src_level = slave_trig_in;
            is_slave = 1'b1;
        end
        else
        begin
            src_level = rf_sample > thr;
            is_master = st_reg.cfg.source >= trig_pkg::SRC_CHANNEL0;
        end
        st_next.slave_mode = is_slave;

        // Slope sets which level is active.
        active = st_reg.cfg.slope_neg ? ~src_level : src_level;
        edge_hit = active && !st_reg.active_prev;
        st_next.active_prev = active;
        hold_cycles = 24'((32'(st_reg.cfg.holdoff) * 32'(trig_pkg::HOLDOFF_UNIT_NS)
            + 32'(trig_pkg::CLK_PERIOD_NS - 1)) / 32'(trig_pkg::CLK_PERIOD_NS));

        // Arming and holdoff.
        case (st_reg.fsm)
            trig_pkg::ST_ARM:
            begin
                if (edge_hit && st_reg.cfg.mode != trig_pkg::MODE_FREERUN)
                begin
                    accept = 1'b1;
                end
            end
            trig_pkg::ST_HOLD:
            begin
                if (st_reg.hold_cnt >= hold_cycles)
                begin
                    st_next.fsm = trig_pkg::ST_ARM;
                end
                else
                begin
                    st_next.hold_cnt = st_reg.hold_cnt + 24'd1;
                end
            end
            trig_pkg::ST_GAP:
            begin
                if (active)
                begin
                    st_next.hold_cnt = 24'd0;
                end
                else if (st_reg.hold_cnt >= hold_cycles)
                begin
                    st_next.fsm = trig_pkg::ST_ARM;
                end
                else
                begin
                    st_next.hold_cnt = st_reg.hold_cnt + 24'd1;
                end
            end
            default: st_next.fsm = trig_pkg::ST_ARM;
        endcase
        if (accept)
        begin
            st_next.hold_cnt = 24'd0;
            st_next.fsm = st_reg.cfg.gap_mode ? trig_pkg::ST_GAP : trig_pkg::ST_HOLD;
            st_next.trig_count = st_reg.trig_count + 32'd1;
            st_next.trig_out = is_master;
        end

        // Self-made sweeps.
        case (st_reg.cfg.mode)
            trig_pkg::MODE_AUTO, trig_pkg::MODE_AUTOLEVEL:
            begin
                if (accept)
                begin
                    st_next.auto_cnt = 32'd0;
                end
                else if (st_reg.auto_cnt >= 32'(AUTO_TIMEOUT - 1))
                begin
                    st_next.auto_cnt = 32'd0;
                    forced = 1'b1;
                end
                else
                begin
                    st_next.auto_cnt = st_reg.auto_cnt + 32'd1;
                end
            end
            trig_pkg::MODE_FREERUN:
            begin
                if (st_reg.auto_cnt >= 32'(FREERUN_PERIOD - 1))
                begin
                    st_next.auto_cnt = 32'd0;
                    forced = 1'b1;
                end
                else
                begin
                    st_next.auto_cnt = st_reg.auto_cnt + 32'd1;
                end
            end
            default: st_next.auto_cnt = 32'd0;
        endcase

        // Positive delay postpones the sweep.
        dly_cycles = 32'(st_reg.cfg.delay / 32'sd100);
        if (st_reg.dly_run)
        begin
            if (st_reg.dly_cnt <= 32'd1)
            begin
                st_next.dly_run = 1'b0;
                st_next.sweep_start = 1'b1;
            end
            else
            begin
                st_next.dly_cnt = st_reg.dly_cnt - 32'd1;
            end
        end
        if (accept || forced)
        begin
            if (st_reg.cfg.delay > 32'sd0 && dly_cycles != 32'd0)
            begin
                st_next.dly_run = 1'b1;
                st_next.dly_cnt = dly_cycles;
            end
            else
            begin
                st_next.dly_run = 1'b0;
                st_next.sweep_start = 1'b1;
            end
        end

        // Pre-trigger span and rate reduction.
        pre_ns = 48'(st_reg.cfg.pos) * 48'(trig_pkg::tb_ns(st_reg.cfg.tb))
            - 48'(st_reg.cfg.delay);
        pre_pos = (pre_ns < 48'sd0) ? 48'h0 : 48'(pre_ns);
        dec = 15;
        for (int i = 15; i >= 0; i--)
        begin
            if ((pre_pos >> i) <= 48'(trig_pkg::PRETRIG_MAX_NS))
            begin
                dec = i;
            end
        end
        st_next.decim = 4'(dec);
        st_next.pretrig = 16'((pre_pos >> dec) / 48'(trig_pkg::CLK_PERIOD_NS));

        // Address phase: latch and prepare read data.
        st_next.a_valid = 1'b0;
        if (hsel && htrans[1] && hready)
        begin
            st_next.a_valid = 1'b1;
            st_next.a_wr = hwrite;
            st_next.a_addr = haddr[7:0];
            if (!hwrite)
            begin
                case (haddr[7:0])
                    trig_pkg::ADDR_CTRL: st_next.rdata = {24'h000000, st_next.cfg.source,
                        st_next.cfg.gap_mode, st_next.cfg.slope_neg, st_next.cfg.mode};
                    trig_pkg::ADDR_TIMEBASE: st_next.rdata = {27'h0000000, st_next.cfg.tb};
                    trig_pkg::ADDR_DELAY: st_next.rdata = st_next.cfg.delay;
                    trig_pkg::ADDR_POSITION: st_next.rdata = 32'(st_next.cfg.pos);
                    trig_pkg::ADDR_LEVEL: st_next.rdata = 32'(st_next.cfg.level);
                    trig_pkg::ADDR_OFFSET: st_next.rdata = 32'(st_next.cfg.offset);
                    trig_pkg::ADDR_HOLDOFF: st_next.rdata = {8'h00, st_next.cfg.holdoff};
                    trig_pkg::ADDR_STATUS: st_next.rdata = {20'h00000, st_next.decim,
                        2'b00, is_master, is_slave, st_next.dly_run, 1'b0, st_next.fsm};
                    trig_pkg::ADDR_TRIG_COUNT: st_next.rdata = st_next.trig_count;
                    trig_pkg::ADDR_PRETRIG: st_next.rdata = {16'h0000, st_next.pretrig};
                    default: st_next.rdata = 32'h00000000;
                endcase
            end
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_reg <= trig_pkg::STATE_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Registered outputs; hresp is tied low.
    assign hreadyout = st_reg.ready;
    assign hrdata = st_reg.rdata;
    assign hresp = 1'b0;
    assign trig_out = st_reg.trig_out;
    assign sweep_start = st_reg.sweep_start;
    assign slave_mode = st_reg.slave_mode;
    assign pretrig_samples = st_reg.pretrig;
    assign decim_shift = st_reg.decim;
endmodule

//--- dv/acquisition_trigger_unit_assertions.sv
`timescale 1ns/100ps
module acquisition_trigger_unit_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic trig_out,
    input wire logic sweep_start,
    input wire logic slave_mode,
    input wire logic [15:0] pretrig_samples,
    input wire logic [3:0] decim_shift
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Read address phase.
    sequence s_rd;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    property p_trig_pulse; trig_out |=> !trig_out; endproperty
    property p_sweep_pulse; sweep_start |=> !sweep_start; endproperty
    property p_master_only; slave_mode |-> !trig_out; endproperty
    property p_pre_cap; pretrig_samples <= 16'h3138; endproperty
    property p_decim_need; decim_shift != 4'h0 |-> pretrig_samples >= 16'h189C; endproperty
    property p_rd_hold; $changed(hrdata) |-> $past(hsel && htrans[1] && hready && !hwrite); endproperty
    property p_zero_read; s_rd ##0 (haddr[7:0] == 8'h1C || haddr[7:0] > 8'h28) |=> hrdata == 32'h0;
    endproperty
    property p_ready; hreadyout |=> hreadyout; endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("trig_out too wide");
    a_sweep_pulse: assert property (p_sweep_pulse) else $error("sweep_start too wide");
    a_master_only: assert property (p_master_only) else $error("slave drove trig_out");
    a_pre_cap: assert property (p_pre_cap) else $error("pre-trigger memory overflow");
    a_decim_need: assert property (p_decim_need) else $error("rate lowered needlessly");
    a_rd_hold: assert property (p_rd_hold) else $error("hrdata changed without a read");
    a_zero_read: assert property (p_zero_read) else $error("blank read not zero");
    a_ready: assert property (p_ready) else $error("hreadyout dropped");
endmodule
bind acquisition_trigger_unit acquisition_trigger_unit_assertions u_chk (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .trig_out, .sweep_start, .slave_mode,
    .pretrig_samples, .decim_shift);

//--- dv/trig_src_model.sv
`timescale 1ns/100ps
module trig_src_model (
    input wire logic hclk,
    input wire logic rf_hi,
    output logic signed [15:0] rf_sample
);
    // Power steps between 15 dBm and -30 dBm.
    always_ff @(posedge hclk)
    begin
        rf_sample <= rf_hi ? 16'sh0096 : -16'sh012C;
    end
endmodule

//--- dv/acquisition_trigger_unit_bench.sv
`timescale 1ns/100ps
module acquisition_trigger_unit_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] lines = 3'h0;
    logic hreadyout, hresp, trig_out, sweep_start, slave_mode;
    logic [31:0] hrdata, q;
    logic signed [15:0] rf_sample;
    logic [15:0] pretrig_samples;
    logic [3:0] decim_shift;
    logic [31:0] seed = 32'hB60C95C5;
    int err_total = 0, num_checks = 0, n_trig = 0, n_sw = 0, n_hi, t0, s0, t, p;
    acquisition_trigger_unit #(.AUTO_TIMEOUT(50), .FREERUN_PERIOD(20), .AUTOLEVEL_WINDOW(30)) uut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rf_sample, .ext_trig_in(lines[1]),
        .slave_trig_in(lines[2]), .own_channel(4'h0), .trig_out, .sweep_start, .slave_mode,
        .pretrig_samples, .decim_shift);
    trig_src_model src (.hclk, .rf_hi(lines[0]), .rf_sample);
    // Clock of 100 ns and pulse counters.
    always #50 hclk = ~hclk;
    always @(posedge hclk)
    begin
        n_trig <= n_trig + int'(trig_out);
        n_sw <= n_sw + int'(sweep_start);
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected shift and samples at zero delay.
    function automatic logic [31:0] pexp(input int tb, input int pos);
        longint pre;
        int d;
        pre = pos * ((tb % 3 == 0) ? 5 : (tb % 3 == 1) ? 10 : 20);
        for (int i = 0; i < tb / 3; i++) pre = pre * 10;
        if (pre < 0) pre = 0;
        d = 0;
        while ((pre >> d) > 1260000) d++;
        return {12'h0, 4'(d), 16'((pre >> d) / 100)};
    endfunction
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Bounded wait for hready.
    task rdy;
        int i;
        i = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && i < 100)
        begin
            @(posedge hclk);
            i++;
        end
        if (i >= 100)
        begin
            err_total++;
            test_done;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        q = hrdata;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    // Burst on line k; n_hi is the count when it ends.
    task pulse(input int k);
        @(posedge hclk);
        lines <= 3'h1 << k;
        repeat (6) @(posedge hclk);
        n_hi = n_trig;
        lines <= 3'h0;
        repeat (6) @(posedge hclk);
    endtask
    // Main sequence.
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd(8'h04, 32'hD, "timebase");
        rd(8'h40, 32'h0, "unmapped");
        bus(1'b1, 8'h08, 32'h80000000);
        rd(8'h08, 32'hFF9FDEA0, "delay_min");
        bus(1'b1, 8'h08, 32'h7FFFFFFF);
        rd(8'h08, 32'h1DCD6500, "delay_max");
        bus(1'b1, 8'h1C, 32'h1);
        rd(8'h08, 32'h0, "delay_zero");
        for (int i = 1; i < 4; i++)
        begin
            bus(1'b1, 8'h1C, 32'h1 << i);
            rd(8'h0C, (i - 1) * 5, "preset");
        end
        bus(1'b1, 8'h0C, 32'hFFFFFFD8);
        rd(8'h0C, 32'hFFFFFFE2, "pos_min");
        bus(1'b1, 8'h10, 32'h3E8);
        rd(8'h10, 32'hC8, "level_cap");
        bus(1'b1, 8'h14, 32'hC8);
        bus(1'b1, 8'h10, 32'h3E8);
        rd(8'h10, 32'h190, "level_offset");
        bus(1'b1, 8'h14, 32'h0);
        bus(1'b1, 8'h10, 32'h0);
        for (int i = 0; i < 5; i++) bus(1'b1, 8'h1C, (i < 2) ? 32'h10 : 32'h20);
        rd(8'h18, 32'h0, "holdoff_floor");
        $display("register tests done");
        for (int i = 0; i < 2; i++)
        begin
            bus(1'b1, 8'h00, i ? 32'h24 : 32'h20);
            repeat (3) @(posedge hclk);
            t0 = n_trig;
            pulse(0);
            chk("slope_early", i ? 0 : 1, n_hi - t0);
            chk("slope_total", 1, n_trig - t0);
        end
        bus(1'b1, 8'h00, 32'h20);
        bus(1'b1, 8'h18, 32'h12C);
        t0 = n_trig;
        pulse(0);
        pulse(0);
        repeat (40) @(posedge hclk);
        pulse(0);
        chk("holdoff", 2, n_trig - t0);
        bus(1'b1, 8'h00, 32'h28);
        repeat (40) @(posedge hclk);
        t0 = n_trig;
        pulse(0);
        pulse(0);
        chk("gap", 1, n_trig - t0);
        bus(1'b1, 8'h18, 32'h0);
        $display("trigger tests done");
        bus(1'b1, 8'h00, 32'h10);
        s0 = n_sw;
        pulse(1);
        chk("external", 1, n_sw - s0);
        bus(1'b1, 8'h00, 32'h30);
        repeat (3) @(posedge hclk);
        chk("slave", 1, slave_mode);
        t0 = n_trig;
        s0 = n_sw;
        pulse(2);
        chk("slave_sweep", 2, (n_sw - s0) * 2 + n_trig - t0);
        bus(1'b1, 8'h00, 32'h20);
        bus(1'b1, 8'h08, 32'h7D0);
        s0 = n_sw;
        pulse(0);
        chk("delay_early", 0, n_sw - s0);
        repeat (20) @(posedge hclk);
        chk("delay_late", 1, n_sw - s0);
        bus(1'b1, 8'h1C, 32'h1);
        bus(1'b1, 8'h00, 32'h23);
        s0 = n_sw;
        t0 = n_trig;
        pulse(0);
        repeat (88) @(posedge hclk);
        chk("freerun", 1, n_sw - s0 >= 4 && n_sw - s0 <= 6 && n_trig == t0);
        bus(1'b1, 8'h00, 32'h21);
        s0 = n_sw;
        t0 = n_trig;
        repeat (120) @(posedge hclk);
        chk("auto", 1, n_sw - s0 >= 2 && n_sw - s0 <= 3 && n_trig == t0);
        pulse(0);
        chk("auto_resync", 1, n_trig - t0);
        bus(1'b1, 8'h00, 32'h22);
        repeat (4) pulse(0);
        rd(8'h10, 32'hFFFFFFB5, "autolevel");
        $display("mode tests done");
        bus(1'b1, 8'h00, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            seed = nx(seed);
            t = (i == 0) ? 21 : int'(seed[4:0] % 22);
            p = (i == 0) ? 30 : int'(seed[15:8] % 61) - 30;
            bus(1'b1, 8'h04, t);
            bus(1'b1, 8'h0C, p);
            repeat (3) @(posedge hclk);
            chk("pretrig", pexp(t, p), {12'h0, decim_shift, pretrig_samples});
        end
        $display("pretrigger tests done");
        test_done;
    end
endmodule
